// ### rtl/ursf_map.svh
`ifndef URSF_MAP_SVH
`define URSF_MAP_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define URSF_STAT_OFS 8'h00
`define URSF_DATA_OFS 8'h04
`define URSF_CTRL_OFS 8'h08
`define URSF_BAUD_OFS 8'h0C
`define URSF_MATCH_OFS 8'h10
`define URSF_ISTAT_OFS 8'h14
`define URSF_ICLR_OFS 8'h18
`define URSF_IEN_OFS 8'h1C
// ----------------------------------------------------------------
// Status bits
// ----------------------------------------------------------------
`define URSF_BRK_BIT 31
`define URSF_FULL_BIT 21
`define URSF_OVR_BIT 19
`define URSF_NOISE_BIT 18
`define URSF_FRAME_BIT 17
`define URSF_PAR_BIT 16
`define URSF_M1_BIT 15
`define URSF_M2_BIT 14
// ----------------------------------------------------------------
// Control bits, match fields, reset values, timing
// ----------------------------------------------------------------
`define URSF_CTRL_PE_BIT 0
`define URSF_CTRL_PODD_BIT 1
`define URSF_CTRL_BKDE_BIT 2
`define URSF_M1_LSB 0
`define URSF_M2_LSB 16
`define URSF_BAUD_RST 16'h0004
`define URSF_OVERSAMPLE 16
`define URSF_SAMPLE_A 4'h7
`define URSF_SAMPLE_B 4'h8
`define URSF_SAMPLE_C 4'h9
`define URSF_BIT_END 4'hF
`define URSF_IRQ_W 4
`endif

// ### rtl/ursf_pkg.sv
package ursf_pkg;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_START = 3'b001,
      RX_DATA = 3'b010,
      RX_PAR = 3'b011,
      RX_STOP = 3'b100
   } ursf_rx_state_t;
   typedef logic [7:0] ursf_char_t;
endpackage : ursf_pkg

// ### rtl/ursf_rx_if.sv
interface ursf_rx_if;
   import ursf_pkg::*;
   logic [15:0] baudDiv;
   logic parityEn;
   logic parityOdd;
   logic done;
   ursf_char_t data;
   logic noise;
   logic frameErr;
   logic parityErr;
   logic isBreak;
   modport sampler (input baudDiv, parityEn, parityOdd,
      output done, data, noise, frameErr, parityErr, isBreak);
   modport status (output baudDiv, parityEn, parityOdd,
      input done, data, noise, frameErr, parityErr, isBreak);
endinterface : ursf_rx_if

// ### rtl/ursf_rx_sampler.sv
`include "ursf_map.svh"
module ursf_rx_sampler (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic rxPin,
   ursf_rx_if.sampler rx
);
   import ursf_pkg::*;
   ursf_rx_state_t state_r, state_nxt;
   logic rxMeta_r, rxSync_r;
   logic [15:0] div_r, div_nxt;
   logic [3:0] sub_r, sub_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic s0_r, s0_nxt, s1_r, s1_nxt;
   logic noise_r, noise_nxt, par_r, par_nxt;
   ursf_char_t shift_r, shift_nxt;
   logic done_r, done_nxt, fe_r, fe_nxt, pe_r, pe_nxt, brk_r, brk_nxt;
   logic nz_r, nz_nxt;
   logic tick, maj, dis;
   assign tick = (div_r == 16'h0000);
   // Majority of three samples; any disagreement marks noise
   assign maj = (s0_r & s1_r) | (s0_r & rxSync_r) | (s1_r & rxSync_r);
   assign dis = (s0_r != s1_r) || (s1_r != rxSync_r);
   always_comb begin
      state_nxt = state_r;
      div_nxt = tick ? rx.baudDiv : div_r - 16'h0001;
      sub_nxt = sub_r;
      bit_nxt = bit_r;
      s0_nxt = s0_r;
      s1_nxt = s1_r;
      noise_nxt = noise_r;
      par_nxt = par_r;
      shift_nxt = shift_r;
      done_nxt = 1'b0;
      fe_nxt = fe_r;
      pe_nxt = pe_r;
      brk_nxt = brk_r;
      nz_nxt = nz_r;
      if (tick) begin
         sub_nxt = sub_r + 4'h1;
         if (state_r == RX_IDLE) begin
            sub_nxt = 4'h0;
            if (!rxSync_r) begin
               state_nxt = RX_START;
               noise_nxt = 1'b0;
               par_nxt = 1'b0;
               bit_nxt = 3'h0;
            end
         end else if (sub_r == `URSF_SAMPLE_A) begin
            s0_nxt = rxSync_r;
         end else if (sub_r == `URSF_SAMPLE_B) begin
            s1_nxt = rxSync_r;
         end else if (sub_r == `URSF_SAMPLE_C) begin
            noise_nxt = noise_r | dis;
            case (state_r)
               RX_START: begin
                  if (maj) begin
                     state_nxt = RX_IDLE;
                  end
               end
               RX_DATA: begin
                  shift_nxt = {maj, shift_r[7:1]};
                  par_nxt = par_r ^ maj;
               end
               RX_PAR: begin
                  par_nxt = par_r ^ maj;
               end
               RX_STOP: begin
                  done_nxt = 1'b1;
                  fe_nxt = ~maj;
                  nz_nxt = noise_r | dis;
                  pe_nxt = rx.parityEn & (par_r ^ rx.parityOdd);
                  brk_nxt = ~maj & (shift_r == 8'h00) & ~par_r;
                  state_nxt = RX_IDLE;
               end
               default: begin
                  state_nxt = RX_IDLE;
               end
            endcase
         end else if (sub_r == `URSF_BIT_END) begin
            case (state_r)
               RX_START: begin
                  state_nxt = RX_DATA;
               end
               RX_DATA: begin
                  bit_nxt = bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     state_nxt = rx.parityEn ? RX_PAR : RX_STOP;
                  end
               end
               RX_PAR: begin
                  state_nxt = RX_STOP;
               end
               default: begin
                  state_nxt = state_r;
               end
            endcase
         end
      end
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         rxMeta_r <= 1'b1;
         rxSync_r <= 1'b1;
         state_r <= RX_IDLE;
         div_r <= 16'h0000;
         sub_r <= 4'h0;
         bit_r <= 3'h0;
         s0_r <= 1'b1;
         s1_r <= 1'b1;
         noise_r <= 1'b0;
         par_r <= 1'b0;
         shift_r <= 8'h00;
         done_r <= 1'b0;
         fe_r <= 1'b0;
         pe_r <= 1'b0;
         brk_r <= 1'b0;
         nz_r <= 1'b0;
      end else begin
         rxMeta_r <= rxPin;
         rxSync_r <= rxMeta_r;
         state_r <= state_nxt;
         div_r <= div_nxt;
         sub_r <= sub_nxt;
         bit_r <= bit_nxt;
         s0_r <= s0_nxt;
         s1_r <= s1_nxt;
         noise_r <= noise_nxt;
         par_r <= par_nxt;
         shift_r <= shift_nxt;
         done_r <= done_nxt;
         fe_r <= fe_nxt;
         pe_r <= pe_nxt;
         brk_r <= brk_nxt;
         nz_r <= nz_nxt;
      end
   end
   assign rx.done = done_r;
   assign rx.data = shift_r;
   assign rx.noise = nz_r;
   assign rx.frameErr = fe_r;
   assign rx.parityErr = pe_r;
   assign rx.isBreak = brk_r;
endmodule : ursf_rx_sampler

// ### rtl/ursf_status.sv
// Functional notes
// - No storing into buffer while overrun set
// - Overrun drops shifted char, buffer kept
// - Writing one clears overrun flag
// - Pending break flag at next char overruns
// - Three samples per bit; disagreement means noise
// - Noise flag bit 18, write one clears
// - Framing flag bit 17 on zero stop
// - Parity flag bit 16 on mismatch when enabled
// - Writing one clears parity flag
// - Match one flag bit 15, write one clears
// - Match two flag bit 14, write one clears
// - Reserved status bits read zero
// - Overrun after stop; other errors not set
// - Reading data clears buffer full flag
//
// Our own choices: the address map and the APB slave port.
`include "ursf_map.svh"
module ursf_status (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic rxPin,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq
);
   import ursf_pkg::*;
   ursf_rx_if rxl ();
   ursf_rx_sampler u_sampler (
      .sys_clk(sys_clk),
      .reset(reset),
      .rxPin(rxPin),
      .rx(rxl.sampler)
   );
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   ursf_char_t data_r, data_nxt;
   logic full_r, full_nxt, ovr_r, ovr_nxt, brk_r, brk_nxt;
   logic nf_r, nf_nxt, fe_r, fe_nxt, pf_r, pf_nxt;
   logic m1_r, m1_nxt, m2_r, m2_nxt;
   logic [2:0] ctrl_r, ctrl_nxt;
   logic [15:0] baud_r, baud_nxt;
   logic [31:0] match_r, match_nxt;
   logic [`URSF_IRQ_W-1:0] ist_r, ist_nxt, ien_r, ien_nxt, iev;
   logic [31:0] prdata_r, prdata_nxt, stat;
   logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_r, irq_nxt;
   logic acc, wr, rd, store, blocked, hit;
   logic [31:0] w1c;
   assign acc = psel & penable & pready_r;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign w1c = (wr && paddr == `URSF_STAT_OFS) ? pwdata : 32'h0000_0000;
   // Overrun takes the character when the buffer is full, the flag is
   // already up, or the break flag is still set with break detection on
   assign blocked = full_r | ovr_r | (ctrl_r[`URSF_CTRL_BKDE_BIT] & brk_r);
   assign store = rxl.done & ~rxl.isBreak & ~blocked;
   assign rxl.baudDiv = baud_r;
   assign rxl.parityEn = ctrl_r[`URSF_CTRL_PE_BIT];
   assign rxl.parityOdd = ctrl_r[`URSF_CTRL_PODD_BIT];
   // ----------------------------------------------------------------
   // Status word
   // ----------------------------------------------------------------
   always_comb begin
      stat = 32'h0000_0000;
      stat[`URSF_BRK_BIT] = brk_r;
      stat[`URSF_FULL_BIT] = full_r;
      stat[`URSF_OVR_BIT] = ovr_r;
      stat[`URSF_NOISE_BIT] = nf_r;
      stat[`URSF_FRAME_BIT] = fe_r;
      stat[`URSF_PAR_BIT] = pf_r;
      stat[`URSF_M1_BIT] = m1_r;
      stat[`URSF_M2_BIT] = m2_r;
   end
   // ----------------------------------------------------------------
   // Flags and receive buffer
   // ----------------------------------------------------------------
   always_comb begin
      data_nxt = data_r;
      full_nxt = full_r;
      ovr_nxt = ovr_r & ~w1c[`URSF_OVR_BIT];
      brk_nxt = brk_r & ~w1c[`URSF_BRK_BIT];
      nf_nxt = nf_r & ~w1c[`URSF_NOISE_BIT];
      fe_nxt = fe_r & ~w1c[`URSF_FRAME_BIT];
      pf_nxt = pf_r & ~w1c[`URSF_PAR_BIT];
      m1_nxt = m1_r & ~w1c[`URSF_M1_BIT];
      m2_nxt = m2_r & ~w1c[`URSF_M2_BIT];
      if (rd && paddr == `URSF_DATA_OFS) begin
         full_nxt = 1'b0;
      end
      if (rxl.done && rxl.isBreak && ctrl_r[`URSF_CTRL_BKDE_BIT]) begin
         brk_nxt = 1'b1;
      end else if (rxl.done && blocked) begin
         ovr_nxt = 1'b1;
      end else if (store) begin
         // Flags describe the character now at the head of the buffer
         data_nxt = rxl.data;
         full_nxt = 1'b1;
         nf_nxt = rxl.noise;
         fe_nxt = rxl.frameErr;
         pf_nxt = rxl.parityErr;
         m1_nxt = (rxl.data == match_r[`URSF_M1_LSB +: 8]);
         m2_nxt = (rxl.data == match_r[`URSF_M2_LSB +: 8]);
      end
   end
   // ----------------------------------------------------------------
   // Control, interrupts and bus answer
   // ----------------------------------------------------------------
   always_comb begin
      ctrl_nxt = ctrl_r;
      baud_nxt = baud_r;
      match_nxt = match_r;
      ien_nxt = ien_r;
      iev = {rxl.done & rxl.isBreak, store & (rxl.noise | rxl.frameErr | rxl.parityErr),
         rxl.done & blocked, store};
      ist_nxt = ist_r;
      if (wr && paddr == `URSF_ICLR_OFS) begin
         ist_nxt = ist_r & ~pwdata[`URSF_IRQ_W-1:0];
      end
      ist_nxt = ist_nxt | iev;
      irq_nxt = |(ist_nxt & ien_r);
      if (wr) begin
         if (paddr == `URSF_CTRL_OFS) begin
            ctrl_nxt = pwdata[2:0];
         end else if (paddr == `URSF_BAUD_OFS) begin
            baud_nxt = pwdata[15:0];
         end else if (paddr == `URSF_MATCH_OFS) begin
            match_nxt = pwdata & 32'h00FF_00FF;
         end else if (paddr == `URSF_IEN_OFS) begin
            ien_nxt = pwdata[`URSF_IRQ_W-1:0];
         end
      end
      hit = 1'b1;
      prdata_nxt = 32'h0000_0000;
      if (paddr == `URSF_STAT_OFS) begin
         prdata_nxt = stat;
      end else if (paddr == `URSF_DATA_OFS) begin
         prdata_nxt = {24'h000000, data_r};
      end else if (paddr == `URSF_CTRL_OFS) begin
         prdata_nxt = {29'h0000_0000, ctrl_r};
      end else if (paddr == `URSF_BAUD_OFS) begin
         prdata_nxt = {16'h0000, baud_r};
      end else if (paddr == `URSF_MATCH_OFS) begin
         prdata_nxt = match_r;
      end else if (paddr == `URSF_ISTAT_OFS) begin
         prdata_nxt = {28'h0000000, ist_r};
      end else if (paddr == `URSF_IEN_OFS) begin
         prdata_nxt = {28'h0000000, ien_r};
      end else if (paddr != `URSF_ICLR_OFS) begin
         hit = 1'b0;
      end
      // Answer sampled in the setup cycle so every access has no wait
      pready_nxt = psel & ~penable;
      pslverr_nxt = psel & ~penable & ~hit;
      if (!(psel && !penable && !pwrite)) begin
         prdata_nxt = 32'h0000_0000;
      end
   end
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         data_r <= 8'h00;
         full_r <= 1'b0;
         ovr_r <= 1'b0;
         brk_r <= 1'b0;
         nf_r <= 1'b0;
         fe_r <= 1'b0;
         pf_r <= 1'b0;
         m1_r <= 1'b0;
         m2_r <= 1'b0;
         ctrl_r <= 3'h0;
         baud_r <= `URSF_BAUD_RST;
         match_r <= 32'h0000_0000;
         ist_r <= 4'h0;
         ien_r <= 4'h0;
         irq_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         data_r <= data_nxt;
         full_r <= full_nxt;
         ovr_r <= ovr_nxt;
         brk_r <= brk_nxt;
         nf_r <= nf_nxt;
         fe_r <= fe_nxt;
         pf_r <= pf_nxt;
         m1_r <= m1_nxt;
         m2_r <= m2_nxt;
         ctrl_r <= ctrl_nxt;
         baud_r <= baud_nxt;
         match_r <= match_nxt;
         ist_r <= ist_nxt;
         ien_r <= ien_nxt;
         irq_r <= irq_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence sOverrunChar;
      rxl.done && !rxl.isBreak && blocked;
   endsequence
   sequence sStoredChar;
      store;
   endsequence
   a_ovr_blocks_store: assert property (ovr_r && rxl.done |=> $stable(data_r))
      else $error("buffer written while overrun set");
   a_ovr_keeps_flags: assert property (sOverrunChar |=> ovr_r && $stable(data_r)
      && nf_r == $past(nf_r & ~w1c[18]) && fe_r == $past(fe_r & ~w1c[17]))
      else $error("overrun did not set or flags changed");
   a_ovr_w1c_clear: assert property (ovr_r && w1c[19] && !rxl.done |=> !ovr_r)
      else $error("overrun not cleared by write of one");
   a_brk_forces_ovr: assert property (brk_r && ctrl_r[2] && rxl.done && !rxl.isBreak
      |=> ovr_r)
      else $error("pending break did not cause overrun");
   a_char_flags: assert property (sStoredChar |=> nf_r == $past(rxl.noise)
      && fe_r == $past(rxl.frameErr) && pf_r == $past(rxl.parityErr))
      else $error("error flags do not follow stored character");
   a_match_flags: assert property (sStoredChar |=> m1_r == (data_r == $past(match_r[7:0]))
      && m2_r == (data_r == $past(match_r[23:16])))
      else $error("match flags wrong");
   a_pf_fe_clear: assert property (w1c[16] && w1c[17] && !rxl.done |=> !pf_r && !fe_r)
      else $error("parity or framing flag not cleared");
   a_full_read_clear: assert property (rd && paddr == 8'h04 && !rxl.done |=> !full_r)
      else $error("full flag not cleared by data read");
   a_reserved_zero: assert property (pready_r && !pwrite && paddr == 8'h00
      |-> (prdata_r & 32'h7FD0_3FFF) == 32'h0000_0000)
      else $error("reserved status bits not zero");
   // ----------------------------------------------------------------
   // Bus, interrupt and sticky flag checks
   // ----------------------------------------------------------------
   sequence sSetupPhase;
      psel && !penable;
   endsequence
   sequence sAccessPhase;
      psel && penable && pready_r;
   endsequence
   sequence sBreakChar;
      rxl.done && rxl.isBreak && ctrl_r[`URSF_CTRL_BKDE_BIT];
   endsequence
   // Zero wait states, so a master never has to poll for long
   a_bus_ready_next: assert property (sSetupPhase |=> pready_r)
      else $error("ready missing after setup");
   a_bus_ready_pulse: assert property (pready_r && penable |=> !pready_r)
      else $error("ready held past access");
   a_bus_err_unmapped: assert property (sSetupPhase ##0 (paddr[1:0] != 2'b00
      || paddr > `URSF_IEN_OFS) |=> pslverr_r)
      else $error("unmapped access not refused");
   a_bus_err_mapped: assert property (sSetupPhase ##0 (paddr[1:0] == 2'b00
      && paddr <= `URSF_IEN_OFS) |=> !pslverr_r)
      else $error("mapped access refused");
   // Read data idles at zero so stale status never leaks onto the bus
   a_bus_idle_zero: assert property (!pready_r |-> prdata_r == 32'h0000_0000)
      else $error("read data not zero outside access");
   a_data_readback: assert property (sAccessPhase ##0 (!pwrite && paddr == `URSF_DATA_OFS)
      |-> prdata_r == {24'h000000, $past(data_r)})
      else $error("data read does not return buffer");
   a_irq_raise: assert property (|(ist_r & ien_r)
      && !(wr && paddr == `URSF_ICLR_OFS) |=> irq_r)
      else $error("enabled event did not raise interrupt");
   a_irq_masked: assert property (ien_r == 4'h0 |=> !irq_r)
      else $error("interrupt raised while masked");
   a_ist_stored: assert property (sStoredChar |=> ist_r[0])
      else $error("stored character event lost");
   a_ist_overrun: assert property (rxl.done && blocked |=> ist_r[1])
      else $error("overrun event lost");
   a_ist_break: assert property (sBreakChar |=> ist_r[3])
      else $error("break event lost");
   a_ist_clear: assert property (wr && paddr == `URSF_ICLR_OFS && pwdata[0] && !store
      |=> !ist_r[0])
      else $error("event not cleared by write of one");
   a_ctrl_write: assert property (wr && paddr == `URSF_CTRL_OFS
      |=> ctrl_r == $past(pwdata[2:0]))
      else $error("control write lost");
   // Sticky flags clear only on a write of one or a new stored character
   a_ovr_sticky: assert property (ovr_r && !w1c[19] |=> ovr_r)
      else $error("overrun dropped without write of one");
   a_ovr_no_store: assert property (ovr_r && rxl.done |=> !$rose(full_r))
      else $error("buffer filled while overrun set");
   a_brk_not_stored: assert property (sBreakChar |=> brk_r && $stable(data_r))
      else $error("break character not flagged or stored");
   a_brk_w1c_clear: assert property (brk_r && w1c[31] && !rxl.done |=> !brk_r)
      else $error("break flag not cleared by write of one");
   a_nf_w1c_clear: assert property (nf_r && w1c[18] && !rxl.done |=> !nf_r)
      else $error("noise flag not cleared by write of one");
   a_pf_sticky: assert property (pf_r && !w1c[16] && !store |=> pf_r)
      else $error("parity flag dropped without write of one");
   a_fe_sticky: assert property (fe_r && !w1c[17] && !store |=> fe_r)
      else $error("framing flag dropped without write of one");
   a_match_w1c_clear: assert property (w1c[15] && w1c[14] && !rxl.done
      |=> !m1_r && !m2_r)
      else $error("match flags not cleared by write of one");
   a_full_on_store: assert property (sStoredChar
      |=> full_r && data_r == $past(rxl.data))
      else $error("stored character not held in buffer");
endmodule : ursf_status

// ### tb/ursf_tx_model.sv
// ----------------------------------------------------------------
// Remote serial transmitter driving the receive line
// ----------------------------------------------------------------
module ursf_tx_model
   import ursf_pkg::*;
#(
   parameter int BIT_CLKS = 64
) (
   input wire logic sys_clk,
   output logic rxPin
);
   timeunit 1ns;
   timeprecision 1ns;

   initial rxPin = 1'h1;

   // Glitch is one sample tick wide: it can hit only one of the three
   // mid-bit samples, so the majority survives and only noise shows
   task automatic hold(input logic level, input logic glitch);
      for (int i = 0; i < BIT_CLKS; i++) begin
         @(posedge sys_clk);
         rxPin <= (glitch && i >= BIT_CLKS / 2 + 2 && i < BIT_CLKS / 2 + 2 + BIT_CLKS / 16)
            ? ~level : level;
      end
   endtask : hold

   // Line goes back high for one bit after every frame, so a low stop bit
   // is never mistaken for the next start bit
   task automatic send(input ursf_char_t d, input logic parEn, input logic parBit,
         input logic stopBit, input int noisy);
      hold(1'h0, 1'h0);
      for (int b = 0; b < 8; b++) begin
         hold(d[b], noisy == b);
      end
      if (parEn) begin
         hold(parBit, 1'h0);
      end
      hold(stopBit, 1'h0);
      hold(1'h1, 1'h0);
   endtask : send
endmodule : ursf_tx_model

// ### tb/uart_rx_status_flags_tb_top.sv
`include "ursf_map.svh"
module uart_rx_status_flags_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ursf_pkg::*;

   // ----------------------------------------------------------------
   // Constants and signals
   // ----------------------------------------------------------------
   localparam int BAUD = 3;
   localparam int BIT_CLKS = `URSF_OVERSAMPLE * (BAUD + 1);
   localparam logic [7:0] STAT = `URSF_STAT_OFS;
   localparam logic [7:0] DATA = `URSF_DATA_OFS;
   localparam logic [7:0] CTRL = `URSF_CTRL_OFS;
   localparam logic [31:0] FULL = 32'h1 << `URSF_FULL_BIT;
   localparam logic [31:0] OVR = 32'h1 << `URSF_OVR_BIT;
   localparam logic [31:0] NOISE = 32'h1 << `URSF_NOISE_BIT;
   localparam logic [31:0] FRAME = 32'h1 << `URSF_FRAME_BIT;
   localparam logic [31:0] PAR = 32'h1 << `URSF_PAR_BIT;
   localparam logic [31:0] M1 = 32'h1 << `URSF_M1_BIT;
   localparam logic [31:0] M2 = 32'h1 << `URSF_M2_BIT;
   localparam logic [31:0] BRK = 32'h1 << `URSF_BRK_BIT;
   localparam ursf_char_t MV1 = 8'hA5;
   localparam ursf_char_t MV2 = 8'h3C;

   logic sys_clk, reset, rxPin, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   int nErrors = 0;
   int testsRun = 0;

   ursf_status u_ursf_status (.sys_clk(sys_clk), .reset(reset), .rxPin(rxPin), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq));
   ursf_tx_model #(.BIT_CLKS(BIT_CLKS)) u_ursf_tx_model (.sys_clk(sys_clk), .rxPin(rxPin));

   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end

   // ----------------------------------------------------------------
   // Bus and compare tasks
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("Checks %0d, mismatches %0d", testsRun, nErrors);
      if (nErrors == 0 && testsRun > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         nErrors++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'h1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'h1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (pready !== 1'h1) begin
         nErrors++;
         conclude();
      end
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      xfer(a, 1'h1, d, rd, err);
   endtask : wr

   task automatic expRead(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      xfer(a, 1'h0, 32'h0, rd, err);
      check(rd, exp);
   endtask : expRead

   task automatic expIrq(input logic v);
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, {31'h0, v});
   endtask : expIrq

   // One stored character: flags while full, data, flags after read, write-one clear
   task automatic charTest(input ursf_char_t d, input logic pe, input logic pb,
         input logic sb, input int noisy, input logic [31:0] flags);
      u_ursf_tx_model.send(d, pe, pb, sb, noisy);
      expRead(STAT, flags | FULL);
      expRead(DATA, {24'h0, d});
      expRead(STAT, flags);
      wr(STAT, flags);
      expRead(STAT, 32'h0);
   endtask : charTest

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic scnRegisters;
      logic [31:0] rd;
      logic err;
      expRead(STAT, 32'h0);
      expRead(`URSF_BAUD_OFS, {16'h0, `URSF_BAUD_RST});
      xfer(8'h40, 1'h0, 32'h0, rd, err);
      check({31'h0, err}, 32'h1);
      check(rd, 32'h0);
      wr(STAT, 32'hFFFFFFFF);
      expRead(STAT, 32'h0);
      wr(`URSF_BAUD_OFS, BAUD);
      expRead(`URSF_BAUD_OFS, BAUD);
      wr(`URSF_MATCH_OFS, {8'h0, MV2, 8'h0, MV1});
   endtask : scnRegisters

   task automatic scnMatch;
      charTest(MV1, 1'h0, 1'h0, 1'h1, -1, M1);
      charTest(MV2, 1'h0, 1'h0, 1'h1, -1, M2);
   endtask : scnMatch

   task automatic scnErrors;
      wr(CTRL, 32'h1);
      charTest(8'h11, 1'h1, 1'h1, 1'h1, -1, PAR);
      charTest(8'h13, 1'h1, 1'h1, 1'h1, -1, 32'h0);
      wr(CTRL, 32'h3);
      charTest(8'h11, 1'h1, 1'h1, 1'h1, -1, 32'h0);
      charTest(8'h13, 1'h1, 1'h1, 1'h1, -1, PAR);
      wr(CTRL, 32'h0);
      charTest(8'h22, 1'h0, 1'h0, 1'h0, -1, FRAME);
      charTest(8'h5A, 1'h0, 1'h0, 1'h1, 3, NOISE);
      charTest(8'h81, 1'h0, 1'h0, 1'h1, 7, NOISE);
   endtask : scnErrors

   task automatic scnOverrun;
      u_ursf_tx_model.send(8'h01, 1'h0, 1'h0, 1'h1, -1);
      u_ursf_tx_model.send(8'h02, 1'h0, 1'h0, 1'h0, 2);
      expRead(STAT, FULL | OVR);
      expRead(DATA, 32'h01);
      u_ursf_tx_model.send(8'h03, 1'h0, 1'h0, 1'h1, -1);
      expRead(STAT, OVR);
      wr(STAT, ~OVR & ~BRK);
      expRead(STAT, OVR);
      wr(STAT, OVR);
      expRead(STAT, 32'h0);
      charTest(8'h04, 1'h0, 1'h0, 1'h1, -1, 32'h0);
   endtask : scnOverrun

   task automatic scnBreak;
      wr(CTRL, 32'h4);
      u_ursf_tx_model.send(8'h00, 1'h0, 1'h0, 1'h0, -1);
      expRead(STAT, BRK);
      u_ursf_tx_model.send(8'h06, 1'h0, 1'h0, 1'h1, -1);
      expRead(STAT, BRK | OVR);
      wr(STAT, BRK | OVR);
      charTest(8'h07, 1'h0, 1'h0, 1'h1, -1, 32'h0);
      wr(CTRL, 32'h0);
   endtask : scnBreak

   task automatic scnIrq;
      wr(`URSF_ICLR_OFS, 32'hF);
      wr(`URSF_IEN_OFS, 32'h1);
      expIrq(1'h0);
      u_ursf_tx_model.send(8'h08, 1'h0, 1'h0, 1'h1, -1);
      expRead(`URSF_ISTAT_OFS, 32'h1);
      expIrq(1'h1);
      wr(`URSF_IEN_OFS, 32'h0);
      expIrq(1'h0);
      wr(`URSF_IEN_OFS, 32'h1);
      expIrq(1'h1);
      wr(`URSF_ICLR_OFS, 32'h1);
      expIrq(1'h0);
      expRead(`URSF_ISTAT_OFS, 32'h0);
      expRead(`URSF_ICLR_OFS, 32'h0);
      expRead(DATA, 32'h08);
   endtask : scnIrq

   initial begin
      reset = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge sys_clk);
      reset <= 1'h0;
      scnRegisters();
      scnMatch();
      scnErrors();
      scnOverrun();
      scnBreak();
      scnIrq();
      conclude();
   end
endmodule : uart_rx_status_flags_tb_top
